/* File: verilog/ueb_consts.svh */
// constants for the uart enhanced register access block
`ifndef UEB_CONSTS_SVH
`define UEB_CONSTS_SVH
// host-side uart addresses
`define UEB_A_ASR      3'h1
`define UEB_A_LCR      3'h3
`define UEB_A_RFL      3'h3
`define UEB_A_TFL      3'h4
`define UEB_A_ICR      3'h5
`define UEB_A_SPR      3'h7
// line control value that unlocks the 650 register set
`define UEB_LCR_UNLOCK 8'hBF
`define UEB_LCR_DLAB   7
// additional control field positions
`define UEB_ACR_ASR_EN 7
`define UEB_ACR_ICR_RD 6
`define UEB_ACR_TRG_EN 5
`define UEB_ACR_DTR_HI 4
`define UEB_ACR_DTR_LO 3
`define UEB_ACR_ADSR   2
`define UEB_ACR_TXDIS  1
`define UEB_ACR_RXDIS  0
// indexed offsets
`define UEB_I_ACR      8'h00
`define UEB_I_CPR      8'h01
`define UEB_I_TCR      8'h02
`define UEB_I_CKS      8'h03
`define UEB_I_TTL      8'h04
`define UEB_I_RTL      8'h05
`define UEB_I_FCL      8'h06
`define UEB_I_FCH      8'h07
`define UEB_I_ID1      8'h08
`define UEB_I_ID2      8'h09
// reset values
`define UEB_RST_CPR    8'h20
`define UEB_RST_ZERO   8'h00
`endif

/* File: verilog/ueb_pkg.sv */
// types shared by the enhanced register access block
`default_nettype none
package ueb_pkg;
  // what an access at a uart address is routed to
  typedef enum logic [2:0] {
    UEB_SEL_STD,
    UEB_SEL_ASR,
    UEB_SEL_RFL,
    UEB_SEL_TFL,
    UEB_SEL_ICR
  } ueb_sel_t;
  // indexed register file state
  typedef struct packed {
    logic [7:0] additional_control;
    logic [7:0] clock_prescale;
    logic [7:0] sample_clock_times;
    logic [7:0] clock_source_select;
    logic [7:0] ttl;
    logic [7:0] rx_interrupt_threshold;
    logic [7:0] flow_lower_threshold;
    logic [7:0] flow_upper_threshold;
  } ueb_idx_t;
  // top-level access state
  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] scratch_pad;
    logic [1:0] asr_ctl;
    logic [7:0] rdata;
    logic       rvalid;
  } ueb_state_t;
endpackage
`default_nettype wire

/* File: verilog/ueb_decode.sv */
// address decoder for the enhanced register layer
`timescale 1ns/1ps
`default_nettype none
`include "ueb_consts.svh"
module ueb_decode (
  // address and mode qualifiers
  input  wire logic [2:0]     addr_in,
  input  wire logic           dlab_in,
  input  wire logic           unlock_in,
  input  wire logic           asr_en_in,
  input  wire logic           icr_rd_in,
  // routing
  output ueb_pkg::ueb_sel_t   rd_sel_out,
  output ueb_pkg::ueb_sel_t   wr_sel_out
);
  // read routing; status set hides the shared standard registers
  function automatic ueb_pkg::ueb_sel_t rd_route(input logic [2:0] a);
    rd_route = ueb_pkg::UEB_SEL_STD;
    if (a == `UEB_A_ASR && !dlab_in && asr_en_in)
      rd_route = ueb_pkg::UEB_SEL_ASR;  // R1 R2 R7
    else if (a == `UEB_A_RFL && asr_en_in && !unlock_in)
      rd_route = ueb_pkg::UEB_SEL_RFL;  // R9 R7
    else if (a == `UEB_A_TFL && asr_en_in && !unlock_in)
      rd_route = ueb_pkg::UEB_SEL_TFL;  // R2 R4 R10
    else if (a == `UEB_A_ICR && icr_rd_in && !unlock_in)
      rd_route = ueb_pkg::UEB_SEL_ICR;  // R5 R6 R4
  endfunction
  // write routing; fifo levels are read-only so writes fall through
  function automatic ueb_pkg::ueb_sel_t wr_route(input logic [2:0] a);
    wr_route = ueb_pkg::UEB_SEL_STD;
    if (a == `UEB_A_ASR && !dlab_in && asr_en_in)
      wr_route = ueb_pkg::UEB_SEL_ASR;  // R1 R2
    else if (a == `UEB_A_ICR && !unlock_in)
      wr_route = ueb_pkg::UEB_SEL_ICR;  // R4 R8
  endfunction
  // a process, not assigns: the routes also read the mode inputs
  // directly, and an assign would only wake up on the address
  always_comb begin
    rd_sel_out = rd_route(addr_in);
    wr_sel_out = wr_route(addr_in);
  end
endmodule // ueb_decode
`default_nettype wire

/* File: verilog/ueb_index_regs.sv */
// indexed control register set behind the window
`timescale 1ns/1ps
`default_nettype none
`include "ueb_consts.svh"
module ueb_index_regs #(
  parameter logic [7:0] ID_FIRST  = 8'hA5,  // arbitrary value
  parameter logic [7:0] ID_SECOND = 8'h5A   // arbitrary value
) (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  // window access
  input  wire logic [7:0] idx_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  // contents
  output logic [7:0]      rdata_out,
  output ueb_pkg::ueb_idx_t regs_out
);
  ueb_pkg::ueb_idx_t q, d;
  // write decode; unlisted and read-only offsets change nothing
  always_comb begin
    d = q;
    if (wr_in) begin
      unique case (idx_in)
        `UEB_I_ACR: d.additional_control = wdata_in;
        `UEB_I_CPR: d.clock_prescale = wdata_in;
        `UEB_I_TCR: d.sample_clock_times = wdata_in;
        `UEB_I_CKS: d.clock_source_select = wdata_in;
        `UEB_I_TTL: d.ttl = wdata_in;
        `UEB_I_RTL: d.rx_interrupt_threshold = wdata_in;
        `UEB_I_FCL: d.flow_lower_threshold = wdata_in;
        `UEB_I_FCH: d.flow_upper_threshold = wdata_in;
        default:    d = q;  // R16
      endcase
    end
  end
  // read mux; id bytes are constants, untouched by reset
  always_comb begin
    unique case (idx_in)
      `UEB_I_ACR: rdata_out = q.additional_control;
      `UEB_I_CPR: rdata_out = q.clock_prescale;
      `UEB_I_TCR: rdata_out = q.sample_clock_times;
      `UEB_I_CKS: rdata_out = q.clock_source_select;
      `UEB_I_TTL: rdata_out = q.ttl;
      `UEB_I_RTL: rdata_out = q.rx_interrupt_threshold;
      `UEB_I_FCL: rdata_out = q.flow_lower_threshold;
      `UEB_I_FCH: rdata_out = q.flow_upper_threshold;
      `UEB_I_ID1: rdata_out = ID_FIRST;   // R12
      `UEB_I_ID2: rdata_out = ID_SECOND;  // R12
      default:    rdata_out = `UEB_RST_ZERO;
    endcase
  end
  // prescaler resets to a prescale of four, the rest to zero
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q     <= '0;  // R15
      q.clock_prescale <= `UEB_RST_CPR;  // R15
    end else begin
      q <= d;
    end
  end
  assign regs_out = q;
endmodule // ueb_index_regs
`default_nettype wire

/* File: verilog/ueb_top.sv */
// enhanced register access layer of the uart
//
// Function
// R1: status register at 001 only when divisor latch access bit is 0
// R2: status and tx level need additional status enable set
// R3: status writes change only bits 0 and 1
// R4: tx level and window need last line control write not 0xBF
// R5: window read at 101 needs indexed read enable set
// R6: standard register at 101 read while indexed read enable clear
// R7: shared standard registers readable with status enable clear
// R8: window goes to the indexed register named by scratch pad
// R9: rx level register at 011 returns rx fifo count
// R10: tx level register at 100 returns tx fifo count
// R11: software keeps upper flow threshold within 1 to 127
// R12: indexed offsets 08 and 09 return fixed id bytes
// R13: software writes offset into scratch pad before window access
// R14: software clears indexed read enable after an indexed read
// R15: prescaler resets to 0x20, other indexed registers to zero
// R16: window writes to read-only or unlisted offsets do nothing
`timescale 1ns/1ps
`default_nettype none
`include "ueb_consts.svh"
module ueb_top #(
  parameter logic [7:0] ID_FIRST  = 8'hA5,  // arbitrary value
  parameter logic [7:0] ID_SECOND = 8'h5A,  // arbitrary value
  parameter int         CNT_W     = 8
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  // host register port
  input  wire logic [2:0]       addr_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  input  wire logic [7:0]       wdata_in,
  output logic [7:0]            rdata_out,
  output logic                  rvalid_out,
  // standard register set behind this layer
  output logic                  std_wr_out,
  output logic                  std_rd_out,
  input  wire logic [7:0]       std_rdata_in,
  // uart core state
  input  wire logic [CNT_W-1:0] rx_count_in,
  input  wire logic [CNT_W-1:0] tx_count_in,
  input  wire logic [5:0]       asr_status_in,
  // mode seen by the standard set
  output logic                  dlab_out,
  output logic                  unlocked_650_out,
  // additional status control bits
  output logic                  remote_tx_dis_out,
  output logic                  tx_dis_status_out,
  // additional control fields
  output logic                  asr_en_out,
  output logic                  icr_rd_en_out,
  output logic                  trig950_en_out,
  output logic [1:0]            dtr_mode_out,
  output logic                  auto_dsr_out,
  output logic                  tx_disable_out,
  output logic                  rx_disable_out,
  // clock control
  output logic [4:0]            presc_int_out,
  output logic [2:0]            presc_frac_out,
  output logic [3:0]            sample_n_out,
  output logic [7:0]            clk_sel_out,
  // trigger levels and flow thresholds
  output logic [6:0]            tx_trig_out,
  output logic [6:0]            rx_trig_out,
  output logic [6:0]            flow_lo_out,
  output logic [6:0]            flow_hi_out
);

  // register state and next value
  ueb_pkg::ueb_state_t q, d;
  // indexed register file contents
  ueb_pkg::ueb_idx_t   idx;
  // routing of the current access
  ueb_pkg::ueb_sel_t   rd_sel;
  ueb_pkg::ueb_sel_t   wr_sel;
  // window read data and write strobe
  logic [7:0]          idx_rdata;
  logic                idx_wr;
  // decoded modes
  logic                dlab;
  logic                unlock;
  logic                asr_en;
  logic                icr_rd;

  // mode bits come from the line control shadow and the control reg
  assign dlab   = q.line_control[`UEB_LCR_DLAB];
  assign unlock = (q.line_control == `UEB_LCR_UNLOCK);  // R4
  assign asr_en = idx.additional_control[`UEB_ACR_ASR_EN];
  assign icr_rd = idx.additional_control[`UEB_ACR_ICR_RD];

  // extend a fifo count into a byte, bits above the count read zero
  function automatic logic [7:0] lvl(input logic [CNT_W-1:0] c);
    logic [CNT_W+7:0] w;
    w   = {8'h00, c};
    lvl = w[7:0];
  endfunction

  // address routing
  ueb_decode u_decode (
    .addr_in    (addr_in),
    .dlab_in    (dlab),
    .unlock_in  (unlock),
    .asr_en_in  (asr_en),
    .icr_rd_in  (icr_rd),
    .rd_sel_out (rd_sel),
    .wr_sel_out (wr_sel)
  );

  // window writes go to the offset last placed in the scratch pad
  assign idx_wr = wr_in && (wr_sel == ueb_pkg::UEB_SEL_ICR);  // R8

  // indexed control registers
  ueb_index_regs #(
    .ID_FIRST  (ID_FIRST),
    .ID_SECOND (ID_SECOND)
  ) u_index (
    .mclk_in   (mclk_in),
    .rst_b_in  (rst_b_in),
    .idx_in    (q.scratch_pad),  // R8
    .wr_in     (idx_wr),
    .wdata_in  (wdata_in),
    .rdata_out (idx_rdata),
    .regs_out  (idx)
  );

  // standard set sees only accesses this layer does not claim
  // the window claims 101 writes whenever not unlocked; lsr is read-only
  always_comb begin
    std_wr_out = wr_in && (wr_sel == ueb_pkg::UEB_SEL_STD);
    std_rd_out = rd_in && (rd_sel == ueb_pkg::UEB_SEL_STD);  // R6 R7
  end

  // next-state logic
  always_comb begin
    d        = q;
    d.rvalid = 1'b0;
    // snoop every line control write; unlock tracks the last one
    if (wr_in && addr_in == `UEB_A_LCR)
      d.line_control = wdata_in;  // R4
    // scratch pad doubles as the index pointer; 650 mode owns 111
    if (wr_in && addr_in == `UEB_A_SPR && !unlock)
      d.scratch_pad = wdata_in;  // R8
    // only the two disable bits of the status register are writable
    if (wr_in && wr_sel == ueb_pkg::UEB_SEL_ASR)
      d.asr_ctl = wdata_in[1:0];  // R3
    // read data is captured one cycle after the strobe
    if (rd_in) begin
      d.rvalid = 1'b1;
      unique case (rd_sel)
        ueb_pkg::UEB_SEL_ASR:
          d.rdata = {asr_status_in, q.asr_ctl};  // R1 R3
        ueb_pkg::UEB_SEL_RFL:
          d.rdata = lvl(rx_count_in);  // R9
        ueb_pkg::UEB_SEL_TFL:
          d.rdata = lvl(tx_count_in);  // R10
        ueb_pkg::UEB_SEL_ICR:
          d.rdata = idx_rdata;  // R5 R8
        ueb_pkg::UEB_SEL_STD:
          d.rdata = std_rdata_in;  // R6 R7
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // host read answer
  assign rdata_out  = q.rdata;
  assign rvalid_out = q.rvalid;

  // mode outputs for the standard set
  assign dlab_out         = dlab;
  assign unlocked_650_out = unlock;

  // additional status control bits
  assign remote_tx_dis_out = q.asr_ctl[1];
  assign tx_dis_status_out = q.asr_ctl[0];

  // additional control fields
  assign asr_en_out     = asr_en;
  assign icr_rd_en_out  = icr_rd;
  assign trig950_en_out = idx.additional_control[`UEB_ACR_TRG_EN];
  assign dtr_mode_out   = idx.additional_control[`UEB_ACR_DTR_HI:`UEB_ACR_DTR_LO];
  assign auto_dsr_out   = idx.additional_control[`UEB_ACR_ADSR];
  assign tx_disable_out = idx.additional_control[`UEB_ACR_TXDIS];
  assign rx_disable_out = idx.additional_control[`UEB_ACR_RXDIS];

  // clock control fields
  assign presc_int_out  = idx.clock_prescale[7:3];
  assign presc_frac_out = idx.clock_prescale[2:0];
  assign sample_n_out   = idx.sample_clock_times[3:0];
  assign clk_sel_out    = idx.clock_source_select;

  // seven-bit levels; bit 7 of each register is unused
  // no range check on the upper threshold, software keeps it legal
  assign tx_trig_out = idx.ttl[6:0];
  assign rx_trig_out = idx.rx_interrupt_threshold[6:0];
  assign flow_lo_out = idx.flow_lower_threshold[6:0];
  assign flow_hi_out = idx.flow_upper_threshold[6:0];  // R11

endmodule // ueb_top
`default_nettype wire

/* File: sim/ueb_top_asserts.sv */
// assertions on the ports of the enhanced register access layer
`timescale 1ns/1ps
`default_nettype none
module ueb_top_asserts #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic             mclk_in,
  input wire logic             rst_b_in,
  // host port
  input wire logic [2:0]       addr_in,
  input wire logic             wr_in,
  input wire logic             rd_in,
  input wire logic [7:0]       wdata_in,
  input wire logic [7:0]       rdata_out,
  input wire logic             rvalid_out,
  // standard set and core state
  input wire logic             std_wr_out,
  input wire logic             std_rd_out,
  input wire logic [7:0]       std_rdata_in,
  input wire logic [CNT_W-1:0] rx_count_in,
  input wire logic [CNT_W-1:0] tx_count_in,
  input wire logic [5:0]       asr_status_in,
  // mode and control outputs
  input wire logic             dlab_out,
  input wire logic             unlocked_650_out,
  input wire logic             remote_tx_dis_out,
  input wire logic             tx_dis_status_out,
  input wire logic             asr_en_out,
  input wire logic             icr_rd_en_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // levels show only with status enable on and the set not unlocked
  wire logic lvl_ok = asr_en_out && !unlocked_650_out;
  wire logic rd_std = rd_in && std_rd_out;

  a_read_answer: assert property (rd_in |=> rvalid_out)
    else $error("read not answered next cycle");
  a_rx_level: assert property (
    rd_in && addr_in == 3'h3 && lvl_ok |-> !std_rd_out
      ##1 rdata_out == 8'($past(rx_count_in))) else $error("rx level wrong");
  a_tx_level: assert property (
    rd_in && addr_in == 3'h4 && lvl_ok |-> !std_rd_out
      ##1 rdata_out == 8'($past(tx_count_in))) else $error("tx level wrong");
  a_status_read: assert property (
    rd_in && addr_in == 3'h1 && !dlab_out && asr_en_out |-> !std_rd_out
      ##1 rdata_out == {$past(asr_status_in), $past(remote_tx_dis_out),
      $past(tx_dis_status_out)}) else $error("status read wrong");
  a_dlab_std: assert property (
    rd_in && addr_in == 3'h1 && dlab_out |-> std_rd_out)
    else $error("status seen with divisor latch access set");
  a_status_write: assert property (
    wr_in && addr_in == 3'h1 && !dlab_out && asr_en_out |-> !std_wr_out
      ##1 {remote_tx_dis_out, tx_dis_status_out} == 2'($past(wdata_in)))
    else $error("status write wrong");
  a_shared_std: assert property (
    rd_in && addr_in inside {3'h1, 3'h3, 3'h4} && !asr_en_out |-> rd_std
      ##1 rdata_out == $past(std_rdata_in)) else $error("shared std lost");
  a_window_std: assert property (
    rd_in && addr_in == 3'h5 && !icr_rd_en_out |-> rd_std
      ##1 rdata_out == $past(std_rdata_in)) else $error("101 std lost");
  a_unlock_track: assert property (
    wr_in && addr_in == 3'h3 |=> unlocked_650_out == ($past(wdata_in) == 8'hBF))
    else $error("unlock state wrong");
  a_locked_std: assert property (
    rd_in && addr_in inside {3'h4, 3'h5} && unlocked_650_out |-> std_rd_out)
    else $error("level or window decoded while unlocked");
  a_window_claim: assert property (
    wr_in && addr_in == 3'h5 && !unlocked_650_out |-> !std_wr_out)
    else $error("window write leaked to std set");

  c_window_rd: cover property (rd_in && addr_in == 3'h5 && icr_rd_en_out);
  c_status_wr: cover property (wr_in && addr_in == 3'h1 && asr_en_out);
  c_rx_level: cover property (rd_in && addr_in == 3'h3 && lvl_ok);
endmodule // ueb_top_asserts

bind ueb_top ueb_top_asserts #(.CNT_W(CNT_W)) u_asserts (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
  .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
  .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .std_wr_out(std_wr_out), .std_rd_out(std_rd_out),
  .std_rdata_in(std_rdata_in), .rx_count_in(rx_count_in),
  .tx_count_in(tx_count_in), .asr_status_in(asr_status_in),
  .dlab_out(dlab_out), .unlocked_650_out(unlocked_650_out),
  .remote_tx_dis_out(remote_tx_dis_out),
  .tx_dis_status_out(tx_dis_status_out),
  .asr_en_out(asr_en_out), .icr_rd_en_out(icr_rd_en_out));
`default_nettype wire

/* File: sim/ueb_std_model.sv */
// model of the standard register set behind the enhanced layer
`timescale 1ns/1ps
`default_nettype none
module ueb_std_model (
  // clock, reset and host address
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  // strobes and data to the layer
  input  wire logic       wr_stb_in,
  input  wire logic       rd_stb_in,
  output logic [7:0]      rdata_out
);
  logic [7:0] mem_q [8];
  logic [7:0] junk_q;
  // distinct reset pattern per address so misrouting shows up
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 8; i++) mem_q[i] <= 8'hA0 + 8'(i);
      junk_q <= 8'h00;
    end else begin
      junk_q <= junk_q + 8'h3B;
      if (wr_stb_in) mem_q[addr_in] <= wdata_in;
    end
  end
  // unselected set drives changing junk, never a stale byte
  assign rdata_out = rd_stb_in ? mem_q[addr_in] : ~junk_q;
endmodule // ueb_std_model
`default_nettype wire

/* File: sim/uart_enhanced_register_access_bench.sv */
// self-checking bench for the enhanced register access layer
`timescale 1ns/1ps
`default_nettype none
module uart_enhanced_register_access_bench;
  logic       mclk_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] rx_cnt = 8'h21;
  logic [7:0] tx_cnt = 8'h7F;
  logic [5:0] stat = 6'h15;
  logic [7:0] rdata_out, std_rdata;
  logic       rvalid_out, std_wr, std_rd;
  // packed views of split output fields; nets so several ports may drive
  wire  [7:0] presc, ctl, clock_source_select;
  wire  [3:0] smp;
  wire  [6:0] flow_hi, flow_lo, tx_trig, rx_trig;
  int         n_fail = 0;
  int         cmp_count = 0;

  always #5 mclk_in = ~mclk_in;

  // id values are arbitrary
  ueb_top #(.ID_FIRST(8'h3C), .ID_SECOND(8'hC3)) dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .std_wr_out(std_wr), .std_rd_out(std_rd), .std_rdata_in(std_rdata),
    .rx_count_in(rx_cnt), .tx_count_in(tx_cnt), .asr_status_in(stat),
    .dlab_out(), .unlocked_650_out(), .remote_tx_dis_out(),
    .tx_dis_status_out(), .asr_en_out(ctl[7]), .icr_rd_en_out(ctl[6]),
    .trig950_en_out(ctl[5]), .dtr_mode_out(ctl[4:3]), .auto_dsr_out(ctl[2]),
    .tx_disable_out(ctl[1]), .rx_disable_out(ctl[0]),
    .presc_int_out(presc[7:3]),
    .presc_frac_out(presc[2:0]), .sample_n_out(smp), .clk_sel_out(clock_source_select),
    .tx_trig_out(tx_trig), .rx_trig_out(rx_trig), .flow_lo_out(flow_lo),
    .flow_hi_out(flow_hi));

  ueb_std_model u_std (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_stb_in(std_wr), .rd_stb_in(std_rd),
    .rdata_out(std_rdata));

  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // entered just after an edge; strobe held across exactly one edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_in = a;
    wdata_in = d;
    wr_in = 1'b1;
    @(posedge mclk_in);
    #1;
    wr_in = 1'b0;
    // idle edge so the next call never re-raises the strobe at once
    @(posedge mclk_in);
    #1;
  endtask

  // answer is fixed at one cycle, so no wait loop is needed
  task automatic rdc(input string what, input logic [2:0] a,
                     input logic [7:0] exp);
    addr_in = a;
    rd_in = 1'b1;
    @(posedge mclk_in);
    #1;
    rd_in = 1'b0;
    chk("rvalid", 8'h01, {7'h00, rvalid_out});
    chk(what, exp, rdata_out);
    // valid stands one cycle, data holds until the next read
    @(posedge mclk_in);
    #1;
    chk("rvalid end", 8'h00, {7'h00, rvalid_out});
    chk(what, exp, rdata_out);
  endtask

  task automatic iw(input logic [7:0] off, input logic [7:0] d);
    wr(3'h7, off);
    wr(3'h5, d);
  endtask

  task automatic ir(input logic [7:0] off, input logic [7:0] exp,
                    input string what);
    wr(3'h7, off);
    rdc(what, 3'h5, exp);
  endtask

  task automatic s_reset();
    chk("prescale", 8'h20, presc);
    chk("flow hi", 8'h00, {1'b0, flow_hi});
    chk("ctrl", 8'h00, ctl);
    chk("sample", 8'h00, {4'h0, smp});
    chk("clk sel", 8'h00, clock_source_select);
    chk("levels", 8'h00, {1'b0, tx_trig | rx_trig | flow_lo});
  endtask

  // level and status decode across every mode qualifier
  task automatic s_levels();
    rdc("std 001", 3'h1, 8'hA1);
    rdc("std 011", 3'h3, 8'hA3);
    iw(8'h00, 8'h80);
    rdc("rx level", 3'h3, 8'h21);
    rdc("tx level", 3'h4, 8'h7F);
    rdc("status", 3'h1, 8'h54);
    wr(3'h1, 8'hFF);
    rdc("status wr", 3'h1, 8'h57);
    wr(3'h3, 8'h83);
    rdc("std dlab", 3'h1, 8'hA1);
    wr(3'h3, 8'hBF);
    rdc("std locked", 3'h4, 8'hA4);
    wr(3'h5, 8'h66);
    chk("ctrl kept", 8'h80, ctl);
    wr(3'h3, 8'h03);
  endtask

  // indexed set through the window, including ids and bad offsets
  task automatic s_window();
    iw(8'h01, 8'h4B);
    chk("prescale", 8'h4B, presc);
    iw(8'h07, 8'h7F);
    chk("flow hi", 8'h7F, {1'b0, flow_hi});
    iw(8'h08, 8'h11);
    iw(8'h0A, 8'h22);
    iw(8'h00, 8'hC0);
    ir(8'h01, 8'h4B, "cpr");
    ir(8'h07, 8'h7F, "fch");
    ir(8'h08, 8'h3C, "id1");
    ir(8'h09, 8'hC3, "id2");
    ir(8'h0A, 8'h00, "unlisted");
    ir(8'h00, 8'hC0, "acr");
    iw(8'h00, 8'h80);
    rdc("std 101", 3'h5, 8'h66);
  endtask

  // control, sample, clock select, trigger and lower flow fields reach their ports; bit 7 of the levels is dropped
  task automatic s_fields();
    iw(8'h00, 8'h3F);
    chk("ctrl", 8'h3F, ctl);
    iw(8'h02, 8'h0A);
    chk("sample", 8'h0A, {4'h0, smp});
    iw(8'h03, 8'h5C);
    chk("clk sel", 8'h5C, clock_source_select);
    iw(8'h04, 8'h92);
    chk("tx trig", 8'h12, {1'b0, tx_trig});
    iw(8'h05, 8'hB4);
    chk("rx trig", 8'h34, {1'b0, rx_trig});
    iw(8'h06, 8'hD6);
    chk("flow lo", 8'h56, {1'b0, flow_lo});
  endtask

  // second reset: writable set back to defaults, id bytes untouched
  task automatic s_rerst();
    rst_b_in = 1'b0;
    @(posedge mclk_in);
    #1;
    rst_b_in = 1'b1;
    chk("prescale", 8'h20, presc);
    chk("ctrl", 8'h00, ctl);
    chk("clk sel", 8'h00, clock_source_select);
    iw(8'h00, 8'h40);
    ir(8'h08, 8'h3C, "id1 rst");
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge mclk_in);
    #1;
    rst_b_in = 1'b1;
    s_reset();
    s_levels();
    s_window();
    s_fields();
    s_rerst();
    print_verdict();
  end
endmodule // uart_enhanced_register_access_bench
`default_nettype wire
